// ==== tfl_pkg.sv ====
// Package for the tension feedback limit monitor
package tfl_pkg;
  localparam logic [15:0] TFL_OFF        = 16'h270f;   // 9999: function off
  localparam int          TFL_CLK_HZ     = 100000000;
  localparam int          TFL_TICK_NS    = 10000000;   // Wait time unit: 10 ms
  localparam int          TFL_TICK_CYC   = TFL_TICK_NS / 10;
  localparam logic [15:0] TFL_WAIT_MAX   = 16'h2710;   // 100 s in 10 ms units
  localparam logic [15:0] TFL_HYS_MAX    = 16'h0064;   // 100 %
  localparam logic [15:0] TFL_BIAS_MAX   = 16'h01f4;   // 500 N
  localparam logic [15:0] TFL_DIV_PCT    = 16'h0064;
  // APB register offsets
  localparam logic [7:0]  TFL_UPPER_OFS  = 8'h00;
  localparam logic [7:0]  TFL_LOWER_OFS  = 8'h04;
  localparam logic [7:0]  TFL_HYS_OFS    = 8'h08;
  localparam logic [7:0]  TFL_WAIT_OFS   = 8'h0c;
  localparam logic [7:0]  TFL_DEV_OFS    = 8'h10;
  localparam logic [7:0]  TFL_ACT_OFS    = 8'h14;
  localparam logic [7:0]  TFL_SIGN_OFS   = 8'h18;
  localparam logic [7:0]  TFL_BIAS_OFS   = 8'h1c;
  localparam logic [7:0]  TFL_GAIN_OFS   = 8'h20;
  localparam logic [7:0]  TFL_TERM_OFS   = 8'h24;
  localparam logic [7:0]  TFL_STAT_OFS   = 8'h28;
  localparam logic [7:0]  TFL_DIAM_OFS   = 8'h2c;
  // Terminal function codes
  localparam logic [8:0]  TFL_FN_LOW_P   = 9'd14;
  localparam logic [8:0]  TFL_FN_UP_P    = 9'd15;
  localparam logic [8:0]  TFL_FN_BRK_P   = 9'd231;
  localparam logic [8:0]  TFL_FN_LOW_N   = 9'd114;
  localparam logic [8:0]  TFL_FN_UP_N    = 9'd115;
  localparam logic [8:0]  TFL_FN_BRK_N   = 9'd331;
  localparam int          TFL_NTERM      = 4;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tfl_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tfl_apb_rsp_t;
  typedef struct packed {
    logic start;
    logic stopped;
    logic integ_clr;
    logic diff_clr;
    logic integ_hold;
    logic [1:0] gain_sel;
  } tfl_ctl_t;
endpackage

// ==== tfl_monitor.sv ====
// Tension feedback limit monitor with break detection and APB registers
//
// Function
// - Upper flag when feedback above upper limit
// - Lower flag when feedback below lower limit
// - Out of range past wait time: break
// - Freeze winding diameter at break
// - Torque command zero during break
// - Stop by start off, emergency deceleration
// - Break detection output flag
// - Resume when stopped and start off
// - Positive terminal codes 14, 15, 231
// - Negative terminal codes 114, 115, 331
// - Hysteresis applied to upper and lower limit flags
// - Break uses raw comparisons, no hysteresis
// - Hysteresis may keep flag high
// - Deviation flag above deviation limit
// - Action select picks shutoff sources
// - Setting 9999 disables flag and shutoff
// - Signed select passes negative torque
// - Unsigned select clamps negative torque
// - Integral clear by input, hold by gating
// - Differential clear by input
// - Four gain sets, sign-split gains
// - Percent to newton via bias, gain
// - Wait time 0..100 s, 9999 disables
// - Deviation compares absolute value
// - Hysteresis 0..100 percent, 9999 off
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tfl_monitor (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire tfl_pkg::tfl_apb_req_t i_apb,
  output var  tfl_pkg::tfl_apb_rsp_t o_apb,
  input  wire tfl_pkg::tfl_ctl_t     i_ctl,
  input  wire logic signed [15:0]    i_feedback,
  input  wire logic signed [15:0]    i_deviation,
  input  wire logic signed [15:0]    i_pid_pct,
  input  wire logic signed [15:0]    i_torque_raw,
  input  wire logic [15:0]           i_diameter,
  output logic                       o_upper_limit_flag,
  output logic                       o_lower_limit_flag,
  output logic                       o_deviation_limit_flag,
  output logic                       o_break_detect_flag,
  output logic                       o_pid_fault_trip,
  output logic                       o_pid_zero,
  output logic                       o_integ_clear,
  output logic                       o_integ_hold,
  output logic                       o_diff_clear,
  output logic [2:0]                 o_gain_index,
  output logic                       o_emergency_decel,
  output logic signed [15:0]         o_torque_cmd,
  output logic signed [15:0]         o_tension_newton,
  output logic [15:0]                o_diameter_held,
  output logic [tfl_pkg::TFL_NTERM-1:0] o_terminal
);
  import tfl_pkg::*;
  // ****************************************
  // Register file
  // ****************************************
  typedef enum logic [1:0] {TFL_BRK_IDLE, TFL_BRK_ACTIVE} tfl_brk_t;
  tfl_brk_t    brk_state;
  logic [15:0] upper_limit_setting;
  logic [15:0] lower_limit_setting;
  logic [15:0] limit_hysteresis_width;
  logic [15:0] break_wait_time;
  logic [15:0] deviation_limit_setting;
  logic [1:0]  limit_action_select;
  logic [15:0] torque_sign_select;
  logic [15:0] tension_bias_newton;
  logic [15:0] tension_gain_newton;
  logic [8:0]  output_terminal_function_select [TFL_NTERM];
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] next_rdata;
  // Write lands once, at the edge where the master samples pready
  assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready;
  assign rd_en = i_apb.psel & i_apb.penable & ~i_apb.pwrite;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      upper_limit_setting     <= TFL_OFF;
      lower_limit_setting     <= TFL_OFF;
      limit_hysteresis_width  <= TFL_OFF;
      break_wait_time         <= TFL_OFF;
      deviation_limit_setting <= TFL_OFF;
      limit_action_select     <= 2'h0;
      torque_sign_select      <= 16'h0000;
      tension_bias_newton     <= 16'h0000;
      tension_gain_newton     <= TFL_OFF;
    end else if (wr_en) begin
      case (i_apb.paddr)
        TFL_UPPER_OFS: upper_limit_setting     <= i_apb.pwdata[15:0];
        TFL_LOWER_OFS: lower_limit_setting     <= i_apb.pwdata[15:0];
        TFL_HYS_OFS:   limit_hysteresis_width  <= i_apb.pwdata[15:0];
        TFL_WAIT_OFS:  break_wait_time         <= i_apb.pwdata[15:0];
        TFL_DEV_OFS:   deviation_limit_setting <= i_apb.pwdata[15:0];
        TFL_ACT_OFS:   limit_action_select     <= i_apb.pwdata[1:0];
        TFL_SIGN_OFS:  torque_sign_select      <= i_apb.pwdata[15:0];
        TFL_BIAS_OFS:  tension_bias_newton     <= (i_apb.pwdata[15:0] > TFL_BIAS_MAX) ?
                                                  TFL_BIAS_MAX : i_apb.pwdata[15:0];
        TFL_GAIN_OFS:  tension_gain_newton     <= i_apb.pwdata[15:0];
        default: ;
      endcase
    end
  end
  // Terminal selects, one 9-bit field per 16-bit half
  genvar g;
  generate
    for (g = 0; g < TFL_NTERM; g++) begin : g_term_sel
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          output_terminal_function_select[g] <= 9'h000;
        end else if (wr_en && i_apb.paddr == TFL_TERM_OFS + 8'(4 * (g / 2))) begin
          output_terminal_function_select[g] <= i_apb.pwdata[16*(g%2) +: 9];
        end
      end
    end
  endgenerate
  always_comb begin
    addr_ok    = 1'b1;
    next_rdata = 32'h0000_0000;
    case (i_apb.paddr)
      TFL_UPPER_OFS: next_rdata[15:0] = upper_limit_setting;
      TFL_LOWER_OFS: next_rdata[15:0] = lower_limit_setting;
      TFL_HYS_OFS:   next_rdata[15:0] = limit_hysteresis_width;
      TFL_WAIT_OFS:  next_rdata[15:0] = break_wait_time;
      TFL_DEV_OFS:   next_rdata[15:0] = deviation_limit_setting;
      TFL_ACT_OFS:   next_rdata[1:0]  = limit_action_select;
      TFL_SIGN_OFS:  next_rdata[15:0] = torque_sign_select;
      TFL_BIAS_OFS:  next_rdata[15:0] = tension_bias_newton;
      TFL_GAIN_OFS:  next_rdata[15:0] = tension_gain_newton;
      TFL_TERM_OFS:  next_rdata = {7'h00, output_terminal_function_select[1],
                                  7'h00, output_terminal_function_select[0]};
      TFL_STAT_OFS:  next_rdata[5:0] = {o_pid_fault_trip, o_break_detect_flag,
                                       o_deviation_limit_flag, o_lower_limit_flag,
                                       o_upper_limit_flag, brk_state == TFL_BRK_ACTIVE};
      TFL_DIAM_OFS:  next_rdata[15:0] = o_diameter_held;
      default:       addr_ok = 1'b0;
    endcase
  end
  // Single wait state: pready in the second access cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_apb <= '0;
    end else begin
      o_apb.pready  <= i_apb.psel & i_apb.penable & ~o_apb.pready;
      o_apb.pslverr <= i_apb.psel & i_apb.penable & ~o_apb.pready & ~addr_ok;
      o_apb.prdata  <= (rd_en & ~o_apb.pready & addr_ok) ? next_rdata : 32'h0000_0000;
    end
  end
  // ****************************************
  // Limit comparisons
  // ****************************************
  logic signed [17:0] fb;
  logic signed [17:0] up_lim;
  logic signed [17:0] lo_lim;
  logic signed [17:0] hys;
  logic               up_en;
  logic               lo_en;
  logic               dev_en;
  logic               raw_up;
  logic               raw_lo;
  logic [15:0]        dev_abs;
  assign fb     = 18'(i_feedback);
  assign up_lim = 18'(signed'({1'b0, upper_limit_setting}));
  assign lo_lim = 18'(signed'({1'b0, lower_limit_setting}));
  assign hys    = (limit_hysteresis_width == TFL_OFF) ? 18'sh0 :
                  18'(signed'({1'b0, (limit_hysteresis_width > TFL_HYS_MAX) ?
                                     TFL_HYS_MAX : limit_hysteresis_width}));
  assign up_en  = upper_limit_setting != TFL_OFF;
  assign lo_en  = lower_limit_setting != TFL_OFF;
  assign dev_en = deviation_limit_setting != TFL_OFF;
  assign raw_up = up_en && fb > up_lim;
  assign raw_lo = lo_en && fb < lo_lim;
  assign dev_abs = i_deviation[15] ? 16'(-i_deviation) : i_deviation;
  // Flags set on the raw crossing, cleared at or past the hysteresis band edge, or when the limit is set to 9999
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_upper_limit_flag <= 1'b0;
    end else if (!up_en) begin
      o_upper_limit_flag <= 1'b0;
    end else if (raw_up) begin
      o_upper_limit_flag <= 1'b1;
    end else if (fb <= up_lim - hys) begin
      o_upper_limit_flag <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_lower_limit_flag <= 1'b0;
    end else if (!lo_en) begin
      o_lower_limit_flag <= 1'b0;
    end else if (raw_lo) begin
      o_lower_limit_flag <= 1'b1;
    end else if (fb >= lo_lim + hys) begin
      o_lower_limit_flag <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_deviation_limit_flag <= 1'b0;
    end else begin
      o_deviation_limit_flag <= dev_en && dev_abs > deviation_limit_setting;
    end
  end
  // ****************************************
  // Break timer and state
  // ****************************************
  logic [19:0] tick_cnt;
  logic [15:0] wait_cnt;
  logic        wait_done;
  logic        brk_en;
  assign brk_en    = break_wait_time != TFL_OFF;
  assign wait_done = wait_cnt >= ((break_wait_time > TFL_WAIT_MAX) ? TFL_WAIT_MAX : break_wait_time);
  always_ff @(posedge i_clk) begin
    if (i_srst || !(raw_up || raw_lo)) begin
      tick_cnt <= 20'h00000;
      wait_cnt <= 16'h0000;
    end else if (tick_cnt == 20'(TFL_TICK_CYC - 1)) begin
      tick_cnt <= 20'h00000;
      if (!wait_done) begin
        wait_cnt <= wait_cnt + 16'h0001;
      end
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      brk_state <= TFL_BRK_IDLE;
    end else begin
      case (brk_state)
        TFL_BRK_IDLE: if (brk_en && (raw_up || raw_lo) && wait_done) begin
          brk_state <= TFL_BRK_ACTIVE;
        end
        TFL_BRK_ACTIVE: if (i_ctl.stopped && !i_ctl.start) begin
          brk_state <= TFL_BRK_IDLE;
        end
        default: brk_state <= TFL_BRK_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_diameter_held <= 16'h0000;
    end else if (brk_state != TFL_BRK_ACTIVE) begin
      o_diameter_held <= i_diameter;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_break_detect_flag <= 1'b0;
      o_pid_zero          <= 1'b0;
      o_emergency_decel   <= 1'b0;
    end else begin
      o_break_detect_flag <= brk_state == TFL_BRK_ACTIVE;
      o_pid_zero          <= brk_state == TFL_BRK_ACTIVE;
      o_emergency_decel   <= brk_state == TFL_BRK_ACTIVE && !i_ctl.start;
    end
  end
  // ****************************************
  // Protective trip
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pid_fault_trip <= 1'b0;
    end else if ((limit_action_select[0] && (raw_up || raw_lo)) ||
                 (limit_action_select[1] && o_deviation_limit_flag)) begin
      o_pid_fault_trip <= 1'b1;
    end
  end
  // ****************************************
  // PID side controls and torque output
  // ****************************************
  logic signed [31:0] conv;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_integ_clear <= 1'b0;
      o_integ_hold  <= 1'b0;
      o_diff_clear  <= 1'b0;
      o_gain_index  <= 3'h0;
    end else begin
      o_integ_clear <= i_ctl.integ_clr;
      o_integ_hold  <= i_ctl.integ_hold & ~i_ctl.integ_clr;
      o_diff_clear  <= i_ctl.diff_clr;
      o_gain_index  <= {i_ctl.gain_sel, i_deviation[15]};
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_torque_cmd <= 16'sh0000;
    end else if (brk_state == TFL_BRK_ACTIVE) begin
      o_torque_cmd <= 16'sh0000;
    end else if (i_torque_raw < 0 && torque_sign_select == TFL_OFF) begin
      o_torque_cmd <= 16'sh0000;
    end else begin
      o_torque_cmd <= i_torque_raw;
    end
  end
  // Newton = bias + pct * gain / 100; gain off treats pct as newton
  assign conv = (tension_gain_newton == TFL_OFF) ? 32'(i_pid_pct) :
                32'(signed'({1'b0, tension_bias_newton})) +
                (32'(i_pid_pct) * 32'(signed'({1'b0, tension_gain_newton}))) /
                32'(signed'({1'b0, TFL_DIV_PCT}));
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tension_newton <= 16'sh0000;
    end else begin
      o_tension_newton <= conv[15:0];
    end
  end
  // ****************************************
  // Output terminals
  // ****************************************
  generate
    for (g = 0; g < TFL_NTERM; g++) begin : g_term
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_terminal[g] <= 1'b0;
        end else begin
          case (output_terminal_function_select[g])
            TFL_FN_LOW_P: o_terminal[g] <= o_lower_limit_flag;
            TFL_FN_UP_P:  o_terminal[g] <= o_upper_limit_flag;
            TFL_FN_BRK_P: o_terminal[g] <= o_break_detect_flag;
            TFL_FN_LOW_N: o_terminal[g] <= ~o_lower_limit_flag;
            TFL_FN_UP_N:  o_terminal[g] <= ~o_upper_limit_flag;
            TFL_FN_BRK_N: o_terminal[g] <= ~o_break_detect_flag;
            default:      o_terminal[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate
  // ****************************************
  // Assertions
  // ****************************************
  upper_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    raw_up |=> o_upper_limit_flag) else $error("upper flag not set");
  lower_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    raw_lo |=> o_lower_limit_flag) else $error("lower flag not set");
  break_torque_a: assert property (@(posedge i_clk) disable iff (i_srst)
    brk_state == TFL_BRK_ACTIVE |=> o_torque_cmd == 16'sh0000) else $error("torque not zero");
  diam_freeze_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $past(brk_state) == TFL_BRK_ACTIVE && brk_state == TFL_BRK_ACTIVE |=> $stable(o_diameter_held))
    else $error("diameter moved in break");
  break_resume_a: assert property (@(posedge i_clk) disable iff (i_srst)
    brk_state == TFL_BRK_ACTIVE && !(i_ctl.stopped && !i_ctl.start) |=> brk_state == TFL_BRK_ACTIVE)
    else $error("break released early");
  trip_latch_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pid_fault_trip |=> o_pid_fault_trip) else $error("trip released");
  wait_restart_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !(raw_up || raw_lo) |=> wait_cnt == 16'h0000 && tick_cnt == 20'h00000) else $error("timer kept");
  dev_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    dev_en && dev_abs > deviation_limit_setting |=> o_deviation_limit_flag) else $error("dev flag");
  sign_clamp_a: assert property (@(posedge i_clk) disable iff (i_srst)
    torque_sign_select == TFL_OFF |=> o_torque_cmd >= 0) else $error("negative torque");
  break_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(brk_state == TFL_BRK_ACTIVE) |=> o_break_detect_flag && o_pid_zero) else $error("break flag");
endmodule
`default_nettype wire

// ==== tfl_far_side.sv ====
// Far side model: motor that coasts down under emergency deceleration
`timescale 1ns/1ps
`default_nettype none
module tfl_far_side #(
  parameter int DECEL_CYC = 20
) (
  input  wire logic i_clk,
  input  wire logic i_start,
  input  wire logic i_emergency_decel,
  output logic      o_stopped
);
  int speed = DECEL_CYC;
  // Speed only falls under emergency stop; start spins it up again
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      speed <= DECEL_CYC;
    end else if (i_emergency_decel && speed > 0) begin
      speed <= speed - 1;
    end
  end
  assign o_stopped = (speed == 0);
endmodule
`default_nettype wire

// ==== tension_feedback_limit_monitor_bench.sv ====
// Self-checking bench for the tension feedback limit monitor
`timescale 1ns/1ps
`default_nettype none
module tension_feedback_limit_monitor_bench;
  import tfl_pkg::*;
  logic               i_clk = 1'b0;
  logic               i_srst = 1'b1;
  tfl_apb_req_t       req = '0;
  tfl_apb_rsp_t       rsp;
  logic               start = 1'b1;
  logic               stopped;
  logic [4:0]         pid_ctl = '0;
  logic signed [15:0] fb = '0, dev = '0, pct = '0, trq = '0;
  logic [15:0]        diam = '0;
  tfl_ctl_t           ctl;
  logic               up, lo, dvf, brk, trip, pz, ic, ih, dc, ed;
  logic [2:0]         gidx;
  logic signed [15:0] tcmd, ten;
  logic [15:0]        dheld;
  logic [3:0]         term;
  logic [31:0]        rd;
  logic               err;
  int                 bad_count = 0;
  int                 compares = 0;
  int                 n, e;
  int                 codes [6] = '{14, 15, 231, 114, 115, 331};
  logic [5:0]         cexp = 6'b101010;
  assign ctl = '{start, stopped, pid_ctl[4], pid_ctl[3], pid_ctl[2], pid_ctl[1:0]};
  tfl_monitor uut (.i_clk(i_clk), .i_srst(i_srst), .i_apb(req), .o_apb(rsp), .i_ctl(ctl),
    .i_feedback(fb), .i_deviation(dev), .i_pid_pct(pct), .i_torque_raw(trq), .i_diameter(diam),
    .o_upper_limit_flag(up), .o_lower_limit_flag(lo), .o_deviation_limit_flag(dvf),
    .o_break_detect_flag(brk), .o_pid_fault_trip(trip), .o_pid_zero(pz), .o_integ_clear(ic),
    .o_integ_hold(ih), .o_diff_clear(dc), .o_gain_index(gidx), .o_emergency_decel(ed),
    .o_torque_cmd(tcmd), .o_tension_newton(ten), .o_diameter_held(dheld), .o_terminal(term));
  tfl_far_side far (.i_clk(i_clk), .i_start(start), .i_emergency_decel(ed), .o_stopped(stopped));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task end_sim;
    $display("Checks %0d, errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge i_clk);
    if (k >= 20) begin
      bad_count++;
      end_sim;
    end
  endtask
  initial begin
    void'($urandom(32'h895e));
    step(3);
    i_srst <= 1'b0;
    apb(1'b0, TFL_UPPER_OFS, 32'h0);
    check("upper reset", rd, 32'(TFL_OFF));
    apb(1'b0, TFL_WAIT_OFS, 32'h0);
    check("wait reset", rd, 32'(TFL_OFF));
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, TFL_UPPER_OFS, 32'd600);
    apb(1'b1, TFL_LOWER_OFS, 32'd400);
    apb(1'b1, TFL_DEV_OFS, 32'd100);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, TFL_SIGN_OFS, s ? 32'(TFL_OFF) : 32'h0);
      repeat (16) begin
        fb <= 16'(300 + $urandom_range(400));
        dev <= 16'(int'($urandom_range(400)) - 200);
        trq <= 16'($urandom);
        pct <= 16'($urandom);
        pid_ctl <= 5'($urandom);
        diam <= 16'($urandom);
        step(3);
        check("upper", 32'(up), 32'(fb > 600));
        check("lower", 32'(lo), 32'(fb < 400));
        check("dev", 32'(dvf), 32'(((dev < 0) ? -int'(dev) : int'(dev)) > 100));
        e = (s == 1 && trq < 0) ? 0 : int'(trq);
        check("torque", 32'(tcmd), e);
        check("tension", 32'(ten), 32'(pct));
        check("pidctl", {ic, dc, ih, gidx}, {pid_ctl[4:3], pid_ctl[2] & ~pid_ctl[4], pid_ctl[1:0], dev < 0});
      end
    end
    apb(1'b1, TFL_BIAS_OFS, 32'd600);
    apb(1'b0, TFL_BIAS_OFS, 32'h0);
    check("bias clamp", rd, 32'(TFL_BIAS_MAX));
    apb(1'b1, TFL_GAIN_OFS, 32'd200);
    pct <= 16'sd100;
    step(3);
    check("tension gain", 32'(ten), 32'd700);
    fb <= 16'sd700;
    dev <= 16'sd0;
    trq <= 16'sd77;
    diam <= 16'h1234;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, TFL_TERM_OFS, 32'(codes[k]) | (32'(codes[k]) << 16));
      apb(1'b1, TFL_TERM_OFS + 8'h04, 32'(codes[k]) | (32'(codes[k]) << 16));
      step(3);
      check("term", 32'(term), {4{cexp[k]}});
    end
    apb(1'b1, TFL_WAIT_OFS, 32'h0);
    step(3);
    check("break", {brk, pz, ed}, 32'h6);
    check("brk torque", 32'(tcmd), 32'h0);
    diam <= 16'h4321;
    step(3);
    check("diam", 32'(dheld), 32'h1234);
    apb(1'b0, TFL_DIAM_OFS, 32'h0);
    check("diam reg", rd, 32'h1234);
    start <= 1'b0;
    fb <= 16'sd500;
    step(3);
    check("edecel", {brk, ed}, 32'h3);
    for (n = 0; n < 100 && brk !== 1'b0; n++) step(1);
    if (n >= 100) begin
      bad_count++;
      end_sim;
    end
    check("resume", {brk, pz}, 32'h0);
    start <= 1'b1;
    apb(1'b1, TFL_WAIT_OFS, 32'(TFL_OFF));
    apb(1'b1, TFL_HYS_OFS, 32'd50);
    fb <= 16'sd700;
    step(3);
    check("hys set", 32'(up), 32'h1);
    fb <= 16'sd580;
    step(3);
    check("hys hold", 32'(up), 32'h1);
    fb <= 16'sd540;
    step(3);
    check("hys clear", 32'(up), 32'h0);
    apb(1'b1, TFL_ACT_OFS, 32'h1);
    fb <= 16'sd700;
    step(3);
    check("trip", 32'(trip), 32'h1);
    apb(1'b0, TFL_STAT_OFS, 32'h0);
    check("status", rd, 32'h22);
    fb <= 16'sd500;
    step(3);
    check("trip latch", 32'(trip), 32'h1);
    i_srst <= 1'b1;
    fb <= 16'sd700;
    step(3);
    i_srst <= 1'b0;
    step(2);
    check("trip reset", 32'(trip), 32'h0);
    check("upper off", 32'(up), 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
